/* hdl/bcr_buck_regs.sv */
// register bank and control outputs for the third and fourth buck channels
`timescale 1ns/10ps
// Overview of operation
// - per-mode enable bit 7 turns the channel on in that power mode
// - active-mode enable bit set turns the channel on in active status
// - bit 6 picks forced pulse-width (1) or auto pulse-skip (0)
// - bits 5..0 give the output voltage code for that mode
// - third buck voltage fields reset to code 100111
// - fourth buck voltage fields reset to code 111101
// - sequencing bits 7..6 set the soft-start ramp rate
// - sequencing bits 5..4 assign the start-up step
// - step enable clear: no start at step, done and good flags ignored
// - sequencing bits 2..0 set delay before soft start begins
// - fault mask set keeps a channel fault off the interrupt output
// - retry enabled: short restarts soft start, other channels keep running
// - retry disabled: short shuts all channels, restart after 100 ms
// - discharge bit set discharges the output while the channel is off
// - phase bit set switches the channel half a period shifted
// - configuration bits 3..2 set the voltage slew rate
// - override control clear: register enable bit has no effect
// - override control set: register enable bit turns channel on/off in place of per-mode bits
// - switching mode still follows per-mode bits under override
module bcr_buck_regs #(
    parameter int WAIT_CYCLES = bcr_pkg::SHUT_WAIT_CYCLES
) (
    input  wire logic                     sys_clk,
    input  wire logic                     sys_rst,
    input  wire bcr_pkg::bcr_req_s        regReq,
    output bcr_pkg::bcr_byte_t            regRdata,
    output logic                          regRvalid,
    input  wire bcr_pkg::bcr_mode_e       powerMode,
    input  wire logic [1:0]               faultFlag,
    input  wire logic [1:0]               shortCircuit,
    input  wire logic [1:0]               softStartDoneFlag,
    input  wire logic [1:0]               powerGoodFlag,
    output bcr_pkg::bcr_chan_s [1:0]      chanCtrl,
    output logic [1:0]                    softStartDoneQual,
    output logic [1:0]                    powerGoodQual,
    output logic [1:0]                    softStartRetry,
    output logic                          allChannelsOff,
    output logic                          startupRestart,
    output logic                          interruptOutN
);
    localparam int NCH = bcr_pkg::NUM_CH;
    localparam int NRG = bcr_pkg::REGS_PER_CH;

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [NCH-1:0][NRG-1:0][7:0] regFile;
    logic [NCH-1:0][NRG-1:0][7:0] next_regFile;

    // the printed map places two registers at one offset: a write there
    // loads both, a read returns the first match in map order
    always_comb begin
        next_regFile = regFile;
        for (int c = 0; c < NCH; c++) begin
            for (int r = 0; r < NRG; r++) begin
                if (regReq.write && regReq.addr == bcr_pkg::REG_OFS[c][r]) begin
                    next_regFile[c][r] = regReq.wdata;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int c = 0; c < NCH; c++) begin
                for (int r = 0; r < NRG; r++) begin
                    regFile[c][r] <= bcr_pkg::REG_RST[c][r];
                end
            end
        end else begin
            regFile <= next_regFile;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    bcr_pkg::bcr_byte_t next_regRdata;
    logic               next_regRvalid;

    always_comb begin
        logic found;
        found          = 1'b0;
        next_regRdata  = bcr_pkg::READ_NONE;
        next_regRvalid = regReq.read;
        for (int c = 0; c < NCH; c++) begin
            for (int r = 0; r < NRG; r++) begin
                if (!found && regReq.addr == bcr_pkg::REG_OFS[c][r]) begin
                    found         = 1'b1;
                    next_regRdata = regFile[c][r];
                end
            end
        end
        if (!regReq.read) begin
            next_regRdata = regRdata;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdata  <= bcr_pkg::READ_NONE;
            regRvalid <= 1'b0;
        end else begin
            regRdata  <= next_regRdata;
            regRvalid <= next_regRvalid;
        end
    end

    // ------------------------------------------------------------
    // short-circuit response
    // ------------------------------------------------------------
    logic [1:0] shortPrev;
    logic [1:0] next_shortPrev;
    logic [1:0] shortEvent;
    logic [1:0] retryEn;
    logic       globalTrigger;
    logic       shutdownBusy;
    logic       restartPulse;

    always_comb begin
        next_shortPrev = shortCircuit;
        for (int c = 0; c < NCH; c++) begin
            retryEn[c] = regFile[c][bcr_pkg::IDX_CFG][bcr_pkg::CFG_RETRY];
        end
        shortEvent    = shortCircuit & ~shortPrev;
        globalTrigger = |(shortEvent & ~retryEn);
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shortPrev <= '0;
        end else begin
            shortPrev <= next_shortPrev;
        end
    end

    bcr_wait_timer #(
        .WAIT_CYCLES (WAIT_CYCLES)
    ) u_wait (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .trigger (globalTrigger),
        .busy    (shutdownBusy),
        .restart (restartPulse)
    );

    // ------------------------------------------------------------
    // channel controls
    // ------------------------------------------------------------
    bcr_pkg::bcr_chan_s [1:0] next_chanCtrl;
    logic [1:0]               next_ssDone;
    logic [1:0]               next_pGood;
    logic [1:0]               next_retry;

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        bcr_channel u_ch (
            .regs        (regFile[g]),
            .powerMode   (powerMode),
            .shutdownAll (shutdownBusy),
            .ctrl        (next_chanCtrl[g])
        );
    end

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            // a disabled step hides its flags from the sequencer
            next_ssDone[c] = softStartDoneFlag[c] & next_chanCtrl[c].startupStepEnable;
            next_pGood[c]  = powerGoodFlag[c] & next_chanCtrl[c].startupStepEnable;
            // retries are unlimited: every new short edge re-arms soft start
            next_retry[c]  = shortEvent[c] & retryEn[c];
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            chanCtrl          <= '0;
            softStartDoneQual <= '0;
            powerGoodQual     <= '0;
            softStartRetry    <= '0;
            allChannelsOff    <= 1'b0;
            startupRestart    <= 1'b0;
        end else begin
            chanCtrl          <= next_chanCtrl;
            softStartDoneQual <= next_ssDone;
            powerGoodQual     <= next_pGood;
            softStartRetry    <= next_retry;
            allChannelsOff    <= shutdownBusy;
            startupRestart    <= restartPulse;
        end
    end

    // ------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------
    logic [1:0] faultMask;
    logic       next_interruptOutN;

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            faultMask[c] = regFile[c][bcr_pkg::IDX_CFG][bcr_pkg::CFG_MASK];
        end
        next_interruptOutN = ~|(faultFlag & ~faultMask);
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            interruptOutN <= 1'b1;
        end else begin
            interruptOutN <= next_interruptOutN;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_shortNoRetry(int c);
        shortEvent[c] && !retryEn[c];
    endsequence

    sequence s_offHeld;
        allChannelsOff && !chanCtrl[0].enable && !chanCtrl[1].enable;
    endsequence

    property p_irqMasked;
        @(posedge sys_clk) disable iff (sys_rst)
        ((faultFlag & ~faultMask) == 2'h0) |=> interruptOutN;
    endproperty
    a_irqMasked: assert property (p_irqMasked) else $error("masked fault pulled irq");

    property p_irqRaised;
        @(posedge sys_clk) disable iff (sys_rst)
        ((faultFlag & ~faultMask) != 2'h0) |=> !interruptOutN;
    endproperty
    a_irqRaised: assert property (p_irqRaised) else $error("unmasked fault missed");

    property p_writeBack;
        @(posedge sys_clk) disable iff (sys_rst)
        (regReq.write && regReq.addr == bcr_pkg::REG_OFS[0][bcr_pkg::IDX_SEQ])
            ##1 !regReq.write
            ##1 (regReq.read && !regReq.write && regReq.addr == $past(regReq.addr, 2))
            |=> regRvalid && regRdata == $past(regReq.wdata, 3);
    endproperty
    a_writeBack: assert property (p_writeBack) else $error("readback mismatch");

    for (genvar g = 0; g < NCH; g++) begin : g_chk
        property p_shortShut;
            @(posedge sys_clk) disable iff (sys_rst)
            s_shortNoRetry(g) |=> ##1 s_offHeld;
        endproperty
        a_shortShut: assert property (p_shortShut) else $error("short kept channels on");

        property p_hiccup;
            @(posedge sys_clk) disable iff (sys_rst)
            (shortEvent[g] && retryEn[g] && !shutdownBusy)
                |=> softStartRetry[g] && !allChannelsOff;
        endproperty
        a_hiccup: assert property (p_hiccup) else $error("hiccup retry missing");

        property p_override;
            @(posedge sys_clk) disable iff (sys_rst)
            (regFile[g][bcr_pkg::IDX_CFG][bcr_pkg::CFG_OVR] && !shutdownBusy)
                |=> chanCtrl[g].enable == $past(regFile[g][bcr_pkg::IDX_CFG][bcr_pkg::CFG_REGEN]);
        endproperty
        a_override: assert property (p_override) else $error("override ignored");

        property p_modeEnable;
            @(posedge sys_clk) disable iff (sys_rst)
            // reset still stands on the releasing edge, so skip that attempt
            (!sys_rst && !regFile[g][bcr_pkg::IDX_CFG][bcr_pkg::CFG_OVR] && !shutdownBusy)
                |=> chanCtrl[g].enable == $past(regFile[g][powerMode][bcr_pkg::SET_EN]);
        endproperty
        a_modeEnable: assert property (p_modeEnable) else $error("mode enable wrong");

        property p_modeBits;
            @(posedge sys_clk) disable iff (sys_rst)
            !sys_rst |=> chanCtrl[g].forcedPulseWidthMode == $past(regFile[g][powerMode][bcr_pkg::SET_FORCED_PULSE_WIDTH_MODE])
                && chanCtrl[g].voltageCode == $past(regFile[g][powerMode][bcr_pkg::VCODE_MSB:0]);
        endproperty
        a_modeBits: assert property (p_modeBits) else $error("mode fields wrong");

        property p_discharge;
            @(posedge sys_clk) disable iff (sys_rst)
            chanCtrl[g].outputDischarge |-> !chanCtrl[g].enable;
        endproperty
        a_discharge: assert property (p_discharge) else $error("discharge while on");

        property p_stepFlags;
            @(posedge sys_clk) disable iff (sys_rst)
            !regFile[g][bcr_pkg::IDX_SEQ][bcr_pkg::SEQ_STEP_EN]
                |=> !softStartDoneQual[g] && !powerGoodQual[g];
        endproperty
        a_stepFlags: assert property (p_stepFlags) else $error("flags not ignored");
    end
endmodule

/* hdl/bcr_channel.sv */
// per-channel decode of the stored registers into control settings
`timescale 1ns/10ps
module bcr_channel (
    input  wire logic [5:0][7:0]          regs,
    input  wire bcr_pkg::bcr_mode_e       powerMode,
    input  wire logic                     shutdownAll,
    output bcr_pkg::bcr_chan_s            ctrl
);
    logic [7:0] setting;
    logic [7:0] seqReg;
    logic [7:0] cfgReg;
    logic       onState;

    always_comb begin
        setting = regs[powerMode];
        seqReg  = regs[bcr_pkg::IDX_SEQ];
        cfgReg  = regs[bcr_pkg::IDX_CFG];
        if (cfgReg[bcr_pkg::CFG_OVR]) begin
            onState = cfgReg[bcr_pkg::CFG_REGEN];
        end else begin
            onState = setting[bcr_pkg::SET_EN];
        end
        // a global short shutdown beats every enable source
        ctrl.enable               = onState & ~shutdownAll;
        ctrl.forcedPulseWidthMode = setting[bcr_pkg::SET_FORCED_PULSE_WIDTH_MODE];
        ctrl.voltageCode          = setting[bcr_pkg::VCODE_MSB:0];
        ctrl.softStartRate        = seqReg[bcr_pkg::SEQ_SSR_LSB +: 2];
        ctrl.startupStep          = seqReg[bcr_pkg::SEQ_STEP_LSB +: 2];
        ctrl.startupStepEnable    = seqReg[bcr_pkg::SEQ_STEP_EN];
        ctrl.startupDelay         = seqReg[bcr_pkg::SEQ_DLY_LSB +: 3];
        ctrl.outputDischarge      = ~ctrl.enable & cfgReg[bcr_pkg::CFG_OUTPUT_DISCHARGE_ENABLE];
        ctrl.phaseShift           = cfgReg[bcr_pkg::CFG_PHASE];
        ctrl.voltageSlewRate      = cfgReg[bcr_pkg::CFG_SLEW_LSB +: 2];
    end
endmodule

/* hdl/bcr_wait_timer.sv */
// shutdown hold-off timer: all channels off, then a restart pulse
`timescale 1ns/10ps
module bcr_wait_timer #(
    parameter int WAIT_CYCLES = bcr_pkg::SHUT_WAIT_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic trigger,
    output logic      busy,
    output logic      restart
);
    typedef enum logic [1:0] {
        TMR_IDLE    = 2'b00,
        TMR_WAIT    = 2'b01,
        TMR_RESTART = 2'b10
    } bcr_tmr_e;

    localparam logic [31:0] LAST = 32'(WAIT_CYCLES - 1);

    bcr_tmr_e    state;
    bcr_tmr_e    next_state;
    logic [31:0] count;
    logic [31:0] next_count;

    always_comb begin
        next_state = state;
        next_count = count;
        unique case (state)
            TMR_IDLE: begin
                next_count = '0;
                if (trigger) begin
                    next_state = TMR_WAIT;
                end
            end
            TMR_WAIT: begin
                next_count = count + 32'h1;
                if (count >= LAST) begin
                    next_state = TMR_RESTART;
                end
            end
            TMR_RESTART: begin
                next_state = TMR_IDLE;
            end
            default: begin
                next_state = TMR_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= TMR_IDLE;
            count <= '0;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    assign busy    = (state != TMR_IDLE);
    assign restart = (state == TMR_RESTART);

    property p_waitEnds;
        @(posedge sys_clk) disable iff (sys_rst)
        (state == TMR_WAIT && count == LAST) |=> restart ##1 !busy;
    endproperty
    a_waitEnds: assert property (p_waitEnds) else $error("hold-off did not end");
endmodule

/* inc/bcr_pkg.sv */
// constants and types for the buck channel configuration register bank
package bcr_pkg;
    // ------------------------------------------------------------
    // register map: [channel][slot], slots follow bcr_mode_e order
    // ------------------------------------------------------------
    localparam int NUM_CH      = 2;
    localparam int REGS_PER_CH = 6;
    localparam int IDX_SEQ     = 4;
    localparam int IDX_CFG     = 5;
    localparam logic [7:0] REG_OFS [NUM_CH][REGS_PER_CH] = '{
        '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35},
        '{8'h41, 8'h30, 8'h42, 8'h43, 8'h44, 8'h45}};
    localparam logic [7:0] REG_RST [NUM_CH][REGS_PER_CH] = '{
        '{8'hE7, 8'hA7, 8'h27, 8'hE7, 8'h2C, 8'hB0},
        '{8'hFD, 8'hBD, 8'hBD, 8'hFD, 8'h1C, 8'hA0}};
    localparam logic [7:0] READ_NONE = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SET_EN       = 7;
    localparam int SET_FORCED_PULSE_WIDTH_MODE     = 6;
    localparam int VCODE_MSB    = 5;
    localparam int SEQ_SSR_LSB  = 6;
    localparam int SEQ_STEP_LSB = 4;
    localparam int SEQ_STEP_EN  = 3;
    localparam int SEQ_DLY_LSB  = 0;
    localparam int CFG_MASK     = 7;
    localparam int CFG_RETRY    = 6;
    localparam int CFG_OUTPUT_DISCHARGE_ENABLE    = 5;
    localparam int CFG_PHASE    = 4;
    localparam int CFG_SLEW_LSB = 2;
    localparam int CFG_REGEN    = 1;
    localparam int CFG_OVR      = 0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ          = 200000;
    localparam int SHUT_WAIT_MS     = 100;
    localparam int SHUT_WAIT_CYCLES = SHUT_WAIT_MS * CLK_KHZ;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef logic [7:0] bcr_byte_t;

    typedef enum logic [1:0] {
        MODE_ACTIVE    = 2'b00,
        MODE_LOW_POWER = 2'b01,
        MODE_HIBERNATE = 2'b10,
        MODE_HIGH_PERF = 2'b11
    } bcr_mode_e;

    typedef struct packed {
        logic      write;
        logic      read;
        bcr_byte_t addr;
        bcr_byte_t wdata;
    } bcr_req_s;

    typedef struct packed {
        logic       enable;
        logic       forcedPulseWidthMode;
        logic [5:0] voltageCode;
        logic [1:0] softStartRate;
        logic [1:0] startupStep;
        logic       startupStepEnable;
        logic [2:0] startupDelay;
        logic       outputDischarge;
        logic       phaseShift;
        logic [1:0] voltageSlewRate;
    } bcr_chan_s;
endpackage

/* tb/bcr_host_model.sv */
// host-side register master driving the strobe request port
`timescale 1ns/10ps
module bcr_host_model (
    input  wire logic               sys_clk,
    output bcr_pkg::bcr_req_s       regReq,
    input  wire bcr_pkg::bcr_byte_t regRdata,
    input  wire logic               regRvalid
);
    initial regReq = '0;
    // gap gives idle edges first, so a slow host is modelled too
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input int gap);
        repeat (gap) @(posedge sys_clk);
        @(posedge sys_clk);
        regReq <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        regReq.write <= 1'b0;
        // released data shows the inverse, never the stale value
        regReq.wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, input int gap, output logic [7:0] d, output logic v);
        repeat (gap) @(posedge sys_clk);
        @(posedge sys_clk);
        regReq <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
        @(posedge sys_clk);
        regReq.read <= 1'b0;
        // answer is registered on the edge that took the read
        #1;
        v = regRvalid;
        d = regRdata;
    endtask
endmodule

/* tb/test_bcr_buck_regs.sv */
// self-checking bench for the buck channel register bank
`timescale 1ns/10ps
module test_bcr_buck_regs;
    localparam int WAIT = 8;
    logic                      sys_clk;
    logic                      sys_rst;
    bcr_pkg::bcr_req_s         regReq;
    bcr_pkg::bcr_byte_t        regRdata;
    logic                      regRvalid;
    bcr_pkg::bcr_mode_e        powerMode;
    logic [1:0]                faultFlag;
    logic [1:0]                shortCircuit;
    logic [1:0]                softStartDoneFlag;
    logic [1:0]                powerGoodFlag;
    bcr_pkg::bcr_chan_s [1:0]  chanCtrl;
    logic [1:0]                softStartDoneQual;
    logic [1:0]                powerGoodQual;
    logic [1:0]                softStartRetry;
    logic                      allChannelsOff;
    logic                      startupRestart;
    logic                      interruptOutN;
    int                        errors = 0;
    int                        comparisons = 0;
    int                        cycles = 0;

    bcr_host_model bcr_host_model_i (.sys_clk(sys_clk), .regReq(regReq),
        .regRdata(regRdata), .regRvalid(regRvalid));
    bcr_buck_regs #(.WAIT_CYCLES(WAIT)) bcr_buck_regs_i (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .regReq(regReq), .regRdata(regRdata), .regRvalid(regRvalid),
        .powerMode(powerMode), .faultFlag(faultFlag), .shortCircuit(shortCircuit),
        .softStartDoneFlag(softStartDoneFlag), .powerGoodFlag(powerGoodFlag),
        .chanCtrl(chanCtrl), .softStartDoneQual(softStartDoneQual),
        .powerGoodQual(powerGoodQual), .softStartRetry(softStartRetry),
        .allChannelsOff(allChannelsOff), .startupRestart(startupRestart),
        .interruptOutN(interruptOutN));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // control outputs follow one edge after the write is taken; two spare edges
    task automatic settle;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    task automatic set_mode(input bcr_pkg::bcr_mode_e m);
        @(posedge sys_clk);
        powerMode <= m;
        settle();
    endtask
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values;
        logic [7:0] d;
        logic       v;
        check(chanCtrl[0].voltageCode, 8'h27, "third code");
        check(chanCtrl[1].voltageCode, 8'h3D, "fourth code");
        for (int c = 0; c < 2; c++) begin
            for (int s = 0; s < 6; s++) begin
                // 0x30 is shared and reads back as third buck active
                if (c == 1 && s == 1) continue;
                bcr_host_model_i.rd(bcr_pkg::REG_OFS[c][s], c, d, v);
                check(v, 8'h01, "read valid");
                check(d, bcr_pkg::REG_RST[c][s], "reset value");
            end
        end
        bcr_host_model_i.wr(8'h36, 8'h5A, 0);
        bcr_host_model_i.rd(8'h36, 0, d, v);
        check({v, d[6:0]}, {1'b1, 7'h00}, "unmapped read");
    endtask
    task automatic t_modes;
        logic [7:0] e;
        for (int m = 3; m >= 0; m--) begin
            set_mode(bcr_pkg::bcr_mode_e'(m));
            for (int c = 0; c < 2; c++) begin
                e = bcr_pkg::REG_RST[c][m];
                check(chanCtrl[c].enable, e[7], "mode enable");
                check(chanCtrl[c].forcedPulseWidthMode, e[6], "mode forced_pulse_width_mode");
                check(chanCtrl[c].voltageCode, e[5:0], "mode code");
            end
        end
    endtask
    task automatic t_seq_cfg;
        logic [7:0] d;
        logic       v;
        bcr_host_model_i.wr(8'h34, 8'hB5, 2);
        bcr_host_model_i.rd(8'h34, 0, d, v);
        check(d, 8'hB5, "seq readback");
        bcr_host_model_i.wr(8'h35, 8'h3C, 0);
        settle();
        check(chanCtrl[0].startupStepEnable, 8'h00, "step enable");
        check(chanCtrl[0].softStartRate, 8'h02, "ramp rate");
        check(chanCtrl[0].startupStep, 8'h03, "step");
        check(chanCtrl[0].startupDelay, 8'h05, "delay");
        check(chanCtrl[0].phaseShift, 8'h01, "phase");
        check(chanCtrl[0].voltageSlewRate, 8'h03, "slew");
        check(chanCtrl[0].outputDischarge, 8'h00, "no discharge while on");
    endtask
    task automatic t_override;
        set_mode(bcr_pkg::MODE_HIBERNATE);
        bcr_host_model_i.wr(8'h35, 8'h3E, 0);
        settle();
        check(chanCtrl[0].enable, 8'h00, "enable bit ignored");
        bcr_host_model_i.wr(8'h35, 8'h3F, 0);
        settle();
        check(chanCtrl[0].enable, 8'h01, "forced on");
        check(chanCtrl[0].forcedPulseWidthMode, 8'h00, "forced_pulse_width_mode from mode");
        bcr_host_model_i.wr(8'h35, 8'h3D, 0);
        set_mode(bcr_pkg::MODE_ACTIVE);
        check(chanCtrl[0].enable, 8'h00, "forced off");
        check(chanCtrl[0].forcedPulseWidthMode, 8'h01, "forced_pulse_width_mode from mode");
        bcr_host_model_i.wr(8'h35, 8'h3C, 0);
    endtask
    task automatic t_step_gate;
        @(posedge sys_clk);
        softStartDoneFlag <= 2'b11;
        powerGoodFlag <= 2'b11;
        settle();
        check(softStartDoneQual, 8'h02, "done gated");
        check(powerGoodQual, 8'h02, "good gated");
        bcr_host_model_i.wr(8'h34, 8'hBD, 0);
        settle();
        check({softStartDoneQual, powerGoodQual}, 8'h0F, "flags pass");
        @(posedge sys_clk);
        softStartDoneFlag <= 2'b00;
        powerGoodFlag <= 2'b00;
    endtask
    task automatic t_fault;
        @(posedge sys_clk);
        faultFlag <= 2'b10;
        settle();
        check(interruptOutN, 8'h01, "masked fault");
        @(posedge sys_clk);
        faultFlag <= 2'b01;
        settle();
        check(interruptOutN, 8'h00, "unmasked fault");
        @(posedge sys_clk);
        faultFlag <= 2'b00;
        settle();
        check(interruptOutN, 8'h01, "fault gone");
    endtask
    task automatic t_retry;
        logic hit = 1'b0;
        logic off = 1'b0;
        bcr_host_model_i.wr(8'h35, 8'h7C, 0);
        settle();
        @(posedge sys_clk);
        shortCircuit <= 2'b01;
        repeat (4) begin
            @(posedge sys_clk);
            #1;
            hit |= softStartRetry[0];
            off |= allChannelsOff | ~chanCtrl[1].enable;
        end
        check({hit, off}, 8'h02, "retry only");
        @(posedge sys_clk);
        shortCircuit <= 2'b00;
    endtask
    task automatic t_shutdown;
        int k = 0;
        bcr_host_model_i.wr(8'h35, 8'h3C, 0);
        settle();
        @(posedge sys_clk);
        shortCircuit <= 2'b10;
        while (allChannelsOff !== 1'b1 && k < 4) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        check(8'(k), 8'h02, "shutdown delay");
        check({chanCtrl[0].enable, chanCtrl[1].enable}, 8'h00, "all off");
        check(chanCtrl[0].outputDischarge, 8'h01, "discharge while off");
        k = 0;
        while (startupRestart !== 1'b1 && k < 50) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        check(8'(k), 8'(WAIT), "hold-off length");
        // hold-off flag still stands on the restart pulse, drops one edge later
        @(posedge sys_clk);
        #1;
        check({allChannelsOff, startupRestart, chanCtrl[1].enable}, 8'h01, "restart");
        @(posedge sys_clk);
        shortCircuit <= 2'b00;
    endtask

    initial begin
        sys_rst = 1'b1;
        powerMode = bcr_pkg::MODE_ACTIVE;
        faultFlag = 2'b00;
        shortCircuit = 2'b00;
        softStartDoneFlag = 2'b00;
        powerGoodFlag = 2'b00;
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        t_reset_values();
        t_modes();
        t_seq_cfg();
        t_override();
        t_step_gate();
        t_fault();
        t_retry();
        t_shutdown();
        test_done();
    end
endmodule
